/* bench/gpcfg_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module gpcfg_chk (
   input wire logic       REF_CLK, RST_N, CFG_WR, HIGH_SPEED, DRIVE_INTERRUPT_LINE, INT_REASON_DISABLE,
   input wire logic       DRIVE_IRQ_LINE_DISABLE, DRIVE_IRQ_QUALIFIED,
   input wire logic [7:0] CFG_ADDR, CFG_WDATA, CFG_RDATA,
   input wire logic [4:0] USER_REPORT_BITS,
   input wire logic [2:0] GP_PIN_O, GP_PIN_OE
);
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!RST_N);
   wire wr_o = CFG_WR && CFG_ADDR == 8'h0F;
   wire wr_v = CFG_WR && CFG_ADDR == 8'h0E;
   pin_dir_a: assert property (wr_o |-> ##2 GP_PIN_OE == ~$past(CFG_WDATA[2:0], 2)) else $error("oe");
   irq_dis_a: assert property (wr_o |=> DRIVE_IRQ_LINE_DISABLE == $past(CFG_WDATA[7])) else $error("irq");
   rsn_dis_a: assert property (wr_o |=> INT_REASON_DISABLE == $past(CFG_WDATA[5])) else $error("rsn");
   user_bits_a: assert property (wr_v |=> USER_REPORT_BITS == $past(CFG_WDATA[7:3])) else $error("user");
   pin_val_a: assert property (wr_v |-> ##2 GP_PIN_O[1:0] == $past(CFG_WDATA[1:0], 2)) else $error("val");
   irq_gate_a: assert property (DRIVE_IRQ_QUALIFIED == ($past(DRIVE_INTERRUPT_LINE) &&
      !$past(DRIVE_IRQ_LINE_DISABLE))) else $error("gate");
   spd_pin_a: assert property (wr_o && CFG_WDATA[4] ##1 !CFG_WR |=> GP_PIN_O[2] == !$past(HIGH_SPEED))
      else $error("speed");
   rd_user_a: assert property ($past(CFG_ADDR) == 8'h0E |-> CFG_RDATA[7:3] == $past(USER_REPORT_BITS))
      else $error("rd");
   cover property (wr_o && CFG_WDATA[4]);
   cover property (DRIVE_IRQ_QUALIFIED);
   cover property (wr_v);
endmodule // gpcfg_chk
bind gpcfg_top gpcfg_chk chk (.*);
`default_nettype wire

/* bench/gpcfg_pad_model.sv */
`timescale 1ns/1ps
`default_nettype none
module gpcfg_pad_model (
   input  wire logic [2:0] pad_o, pad_oe, board_val,
   output logic      [2:0] pad_lvl
);
   // Board drives only released pins, so no fight
   assign pad_lvl = pad_o & pad_oe | board_val & ~pad_oe;
endmodule // gpcfg_pad_model
`default_nettype wire

/* bench/gpcfg_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module gpcfg_tb;
   logic       clk = 0, rst_n = 0, wr = 0, hs = 0, irq = 0, irq_dis, rsn_dis, irq_q;
   logic [7:0] addr = 0, wdata = 0, rdata, v, o;
   logic [4:0] user;
   logic [2:0] pin_i, pin_o, pin_oe, board = 0, lvl;
   int         n_mismatch = 0, n_tests = 0;
   gpcfg_top uut (.REF_CLK(clk), .RST_N(rst_n), .CFG_ADDR(addr), .CFG_WR(wr), .CFG_WDATA(wdata),
      .CFG_RDATA(rdata), .HIGH_SPEED(hs), .USER_REPORT_BITS(user), .DRIVE_IRQ_LINE_DISABLE(irq_dis),
      .INT_REASON_DISABLE(rsn_dis), .DRIVE_INTERRUPT_LINE(irq), .DRIVE_IRQ_QUALIFIED(irq_q),
      .GP_PIN_I(pin_i), .GP_PIN_O(pin_o), .GP_PIN_OE(pin_oe));
   gpcfg_pad_model pads (.pad_o(pin_o), .pad_oe(pin_oe), .board_val(board), .pad_lvl(pin_i));
   initial forever #25 clk = ~clk;
   task automatic chk(input logic [7:0] seen, exp);
      n_tests++;
      n_mismatch += int'(seen !== exp);
      if (seen !== exp) $display("Error t=%0t seen %h exp %h", $time, seen, exp);
   endtask
   task automatic wr_cfg(input logic [7:0] a, d);
      @(posedge clk);
      {wr, addr, wdata} <= {1'b1, a, d};
      @(posedge clk);
      wr <= 0;
   endtask
   task automatic rd_cfg(input logic [7:0] a, exp);
      @(posedge clk);
      addr <= a;
      repeat (2) @(posedge clk);
      #1 chk(rdata, exp);
   endtask
   task automatic test_done;
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      #100000 n_mismatch++;
      test_done;
   end
   initial begin
      void'($urandom(48336));
      repeat (16) @(posedge clk);
      rst_n <= 1;
      rd_cfg(8'h0F, 8'h0F);
      chk({5'h00, pin_oe}, 8'h00);
      rd_cfg(8'h3A, 8'h00);
      $display("reset test done");
      for (int i = 0; i < 24; i++) begin
         v = 8'($urandom);
         o = (i == 0 ? 8'h08 : i == 1 ? 8'h1F : i == 2 ? 8'hB8 : 8'($urandom)) & 8'hBF | 8'h08;
         @(posedge clk);
         {board, hs, irq} <= 5'($urandom);
         wr_cfg(8'h0E, v);
         wr_cfg(8'h0F, o);
         repeat (3) @(posedge clk);
         #1 chk({5'h00, pin_oe}, {5'h00, ~o[2:0]});
         chk({5'h00, irq_dis, rsn_dis, irq_q}, {5'h00, o[7], o[5], irq & ~o[7]});
         lvl = {o[4] ? ~hs : v[2], v[1:0]} & ~o[2:0] | board & o[2:0];
         rd_cfg(8'h0E, {v[7:3], lvl});
         $display("test %0d done", i);
      end
      test_done;
   end
endmodule // gpcfg_tb
`default_nettype wire

/* logic/gpcfg_pin_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface gpcfg_pin_if;
   logic [2:0] dir_in_n;
   logic [2:0] out_val;
   logic       spd_en;
   logic       high_speed;
   logic [2:0] pad_o;
   logic [2:0] pad_oe;
   modport ctrl (output dir_in_n, output out_val, output spd_en, output high_speed,
                 input pad_o, input pad_oe);
   modport pins (input dir_in_n, input out_val, input spd_en, input high_speed,
                 output pad_o, output pad_oe);
endinterface : gpcfg_pin_if
`default_nettype wire

/* logic/gpcfg_pins.sv */
`timescale 1ns/1ps
`default_nettype none
module gpcfg_pins (
   // Clock and reset
   input  wire logic REF_CLK,
   input  wire logic RST_N,
   // Pin control
   gpcfg_pin_if.pins pif
);
   logic [2:0] o_d;
   logic [2:0] o_q;
   logic [2:0] oe_q;

   always_comb begin
      o_d = pif.out_val;
      if (pif.spd_en) begin
         o_d[gpcfg_pkg::GPCFG_SPD_PIN] = ~pif.high_speed;
      end
   end

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         o_q  <= 3'h0;
         oe_q <= 3'h0;
      end else begin
         o_q  <= o_d;
         oe_q <= ~pif.dir_in_n;
      end
   end

   assign pif.pad_o  = o_q;
   assign pif.pad_oe = oe_q;
endmodule : gpcfg_pins
`default_nettype wire

/* logic/gpcfg_pkg.sv */
package gpcfg_pkg;
   // ---------------------------------------------
   // Register offsets
   // ---------------------------------------------
   localparam logic [7:0] GPCFG_OFS_VALUES  = 8'h0E;
   localparam logic [7:0] GPCFG_OFS_OPTIONS = 8'h0F;
   // ---------------------------------------------
   // Field positions
   // ---------------------------------------------
   localparam int GPCFG_USER_LSB  = 3;
   localparam int GPCFG_USER_MSB  = 7;
   localparam int GPCFG_PIN_MSB   = 2;
   localparam int GPCFG_IRQ_DIS   = 7;
   localparam int GPCFG_RSV6      = 6;
   localparam int GPCFG_RSN_DIS   = 5;
   localparam int GPCFG_SPD_EN    = 4;
   localparam int GPCFG_RSV3      = 3;
   localparam int GPCFG_SPD_PIN   = 2;
   // ---------------------------------------------
   // Reset values
   // ---------------------------------------------
   localparam logic [7:0] GPCFG_VALUES_RST  = 8'h00;
   localparam logic [7:0] GPCFG_OPTIONS_RST = 8'h0F;
endpackage : gpcfg_pkg

/* logic/gpcfg_top.sv */
`timescale 1ns/1ps
`default_nettype none
module gpcfg_top (
   // Clock and reset
   input  wire logic       REF_CLK,
   input  wire logic       RST_N,
   // Configuration byte port
   input  wire logic [7:0] CFG_ADDR,
   input  wire logic       CFG_WR,
   input  wire logic [7:0] CFG_WDATA,
   output logic      [7:0] CFG_RDATA,
   // Bridge status and options
   input  wire logic       HIGH_SPEED,
   output logic      [4:0] USER_REPORT_BITS,
   output logic            DRIVE_IRQ_LINE_DISABLE,
   output logic            INT_REASON_DISABLE,
   // Drive interrupt line
   input  wire logic       DRIVE_INTERRUPT_LINE,
   output logic            DRIVE_IRQ_QUALIFIED,
   // General purpose pins
   input  wire logic [2:0] GP_PIN_I,
   output logic      [2:0] GP_PIN_O,
   output logic      [2:0] GP_PIN_OE
);
   // ---------------------------------------------
   // Configuration registers
   // ---------------------------------------------
   logic [7:0] values_q;
   logic [7:0] options_q;
   logic [2:0] pin_smp_q;
   logic [7:0] rdata_d;

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         values_q <= gpcfg_pkg::GPCFG_VALUES_RST;
      end else if (CFG_WR && CFG_ADDR == gpcfg_pkg::GPCFG_OFS_VALUES) begin
         values_q <= CFG_WDATA;
      end
   end

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         options_q <= gpcfg_pkg::GPCFG_OPTIONS_RST;
      end else if (CFG_WR && CFG_ADDR == gpcfg_pkg::GPCFG_OFS_OPTIONS) begin
         options_q <= CFG_WDATA;
      end
   end

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         pin_smp_q <= 3'h0;
      end else begin
         pin_smp_q <= GP_PIN_I;
      end
   end

   // ---------------------------------------------
   // Read back
   // ---------------------------------------------
   always_comb begin
      rdata_d = 8'h00;
      case (CFG_ADDR)
         gpcfg_pkg::GPCFG_OFS_VALUES: begin
            rdata_d = {values_q[gpcfg_pkg::GPCFG_USER_MSB:gpcfg_pkg::GPCFG_USER_LSB], pin_smp_q};
         end
         gpcfg_pkg::GPCFG_OFS_OPTIONS: begin
            rdata_d = options_q;
         end
         default: begin
            rdata_d = 8'h00;
         end
      endcase
   end

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         CFG_RDATA <= 8'h00;
      end else begin
         CFG_RDATA <= rdata_d;
      end
   end

   // ---------------------------------------------
   // Option outputs
   // ---------------------------------------------
   // report bits to pipe
   assign USER_REPORT_BITS       = values_q[gpcfg_pkg::GPCFG_USER_MSB:gpcfg_pkg::GPCFG_USER_LSB];
   assign DRIVE_IRQ_LINE_DISABLE = options_q[gpcfg_pkg::GPCFG_IRQ_DIS];
   assign INT_REASON_DISABLE     = options_q[gpcfg_pkg::GPCFG_RSN_DIS];

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         DRIVE_IRQ_QUALIFIED <= 1'b0;
      end else begin
         DRIVE_IRQ_QUALIFIED <= DRIVE_INTERRUPT_LINE & ~options_q[gpcfg_pkg::GPCFG_IRQ_DIS];
      end
   end

   // ---------------------------------------------
   // Pin drivers
   // ---------------------------------------------
   gpcfg_pin_if pif ();

   assign pif.dir_in_n   = options_q[gpcfg_pkg::GPCFG_PIN_MSB:0];
   assign pif.out_val    = values_q[gpcfg_pkg::GPCFG_PIN_MSB:0];
   assign pif.spd_en     = options_q[gpcfg_pkg::GPCFG_SPD_EN];
   assign pif.high_speed = HIGH_SPEED;

   gpcfg_pins u_pins (
      .REF_CLK (REF_CLK),
      .RST_N   (RST_N),
      .pif     (pif.pins)
   );

   assign GP_PIN_O  = pif.pad_o;
   assign GP_PIN_OE = pif.pad_oe;
endmodule : gpcfg_top
`default_nettype wire
